/* pkg/dcd_pkg.sv */
// constants and types shared by the debug command decoder
`default_nettype none
package dcd_pkg;
  // command codes
  localparam logic [7:0] DCD_CMD_REV = 8'h00;
  localparam logic [7:0] DCD_CMD_STATUS = 8'h02;
  localparam logic [7:0] DCD_CMD_RUNTIME = 8'h03;
  localparam logic [7:0] DCD_CMD_WR_REG = 8'h08;
  localparam logic [7:0] DCD_CMD_RD_REG = 8'h09;
  localparam logic [7:0] DCD_CMD_WR_PMEM = 8'h0A;
  localparam logic [7:0] DCD_CMD_RD_PMEM = 8'h0B;
  localparam logic [7:0] DCD_CMD_WR_DMEM = 8'h0C;
  localparam logic [7:0] DCD_CMD_RD_DMEM = 8'h0D;
  localparam logic [7:0] DCD_CMD_RD_CRC = 8'h0E;
  localparam logic [7:0] DCD_CMD_RSVD_0F = 8'h0F;
  localparam logic [7:0] DCD_CMD_STEP = 8'h10;
  localparam logic [7:0] DCD_CMD_STUFF = 8'h11;
  localparam logic [7:0] DCD_CMD_EXEC = 8'h12;
  // runtime counter
  localparam int DCD_RT_WIDTH = 16;
  localparam logic [15:0] DCD_RT_ZERO = 16'h0000;
  localparam logic [15:0] DCD_RT_MAX = 16'hFFFF;
  // response byte counts, zero values and unit steps
  localparam logic [1:0] DCD_RESP_ONE = 2'h1;
  localparam logic [1:0] DCD_RESP_TWO = 2'h2;
  localparam logic [7:0] DCD_BYTE_ZERO = 8'h00;
  localparam logic [3:0] DCD_ADDR_HI_ZERO = 4'h0;
  localparam logic [11:0] DCD_ADDR_ONE = 12'h001;
  localparam logic [7:0] DCD_COUNT_ONE = 8'h01;
  // decoder states
  typedef enum logic [2:0] {
    DCD_ST_IDLE = 3'b000,
    DCD_ST_RESP = 3'b001,
    DCD_ST_WADDR_HI = 3'b010,
    DCD_ST_WADDR_LO = 3'b011,
    DCD_ST_WCOUNT = 3'b100,
    DCD_ST_WDATA = 3'b101,
    DCD_ST_FWD = 3'b110
  } dcd_state_t;
endpackage
`default_nettype wire

/* rtl/dcd_sat_counter.sv */
// saturating up counter with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module dcd_sat_counter
  import dcd_pkg::*;
#(
  parameter int WIDTH = DCD_RT_WIDTH
)(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic inc_i,
  output logic [WIDTH-1:0] count_o
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  wire at_max = &count_q;

  // clear wins, then count up until all ones
  assign count_d = clr_i ? {WIDTH{1'b0}} :
                   (inc_i && !at_max) ? count_q + {{(WIDTH-1){1'b0}}, 1'b1} : count_q;
  assign count_o = count_q;

  // counter register
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      count_q <= {WIDTH{1'b0}};
    else if (ce_i)
      count_q <= count_d;
  end
endmodule
`default_nettype wire

/* rtl/dcd_decoder.sv */
// debug command decoder: gating, built-in answers and register-write filter
`timescale 1ns/1ps
`default_nettype none
module dcd_decoder
  import dcd_pkg::*;
#(
  parameter logic [15:0] REV_WORD = 16'h0100, // arbitrary revision value
  parameter logic [11:0] FLASH_LO = 12'hFF8,
  parameter logic [11:0] FLASH_HI = 12'hFFF,
  parameter logic [11:0] FLASH_CTRL = 12'hFF8,
  parameter logic [7:0] MASS_ERASE = 8'hA5
)(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  input wire logic tx_ready_i,
  input wire logic debug_mode_i,
  input wire logic read_protect_i,
  input wire logic cpu_running_i,
  input wire logic [7:0] debug_status_byte_i,
  output logic cmd_start_o,
  output logic [7:0] cmd_code_o,
  output logic cmd_refused_o,
  output logic arg_valid_o,
  output logic [7:0] arg_byte_o,
  input wire logic cmd_done_i,
  output logic reg_wr_o,
  output logic [11:0] reg_addr_o,
  output logic [7:0] reg_data_o,
  output logic [15:0] runtime_count_o
);
  dcd_state_t state_q;
  dcd_state_t state_d;
  logic [15:0] resp_q;
  logic [15:0] resp_d;
  logic [1:0] resp_cnt_q;
  logic [1:0] resp_cnt_d;
  logic [11:0] waddr_q;
  logic [11:0] waddr_d;
  logic [7:0] wcount_q;
  logic [7:0] wcount_d;
  logic run_q;
  logic cmd_start_q;
  logic [7:0] cmd_code_q;
  logic cmd_refused_q;
  logic arg_valid_q;
  logic [7:0] arg_byte_q;
  logic reg_wr_q;
  logic [11:0] reg_addr_q;
  logic [7:0] reg_data_q;
  logic [15:0] rt_count;

  // byte handshake: no command bytes are taken while answering
  assign rx_ready_o = (state_q != DCD_ST_RESP);
  assign tx_valid_o = (state_q == DCD_ST_RESP);
  assign tx_byte_o = resp_q[15:8];
  wire take = ce_i && rx_valid_i && rx_ready_o;
  wire sent = ce_i && tx_valid_o && tx_ready_i;
  wire [7:0] code = rx_byte_i;

  // command classification
  wire is_builtin = (code == DCD_CMD_REV) || (code == DCD_CMD_STATUS) ||
                    (code == DCD_CMD_RUNTIME);
  wire need_dbg = (code >= DCD_CMD_WR_REG) && (code <= DCD_CMD_EXEC) &&
                  (code != DCD_CMD_RSVD_0F);
  wire prot_block = (code == DCD_CMD_RD_REG) || (code == DCD_CMD_WR_PMEM) ||
                    (code == DCD_CMD_RD_PMEM) || (code == DCD_CMD_WR_DMEM) ||
                    (code == DCD_CMD_STEP) || (code == DCD_CMD_STUFF) ||
                    (code == DCD_CMD_EXEC);
  wire known = is_builtin || need_dbg;
  wire allowed = known && (!need_dbg || debug_mode_i) &&
                 !(read_protect_i && prot_block);
  wire idle_take = take && (state_q == DCD_ST_IDLE);
  wire fwd_take = idle_take && allowed && !is_builtin && (code != DCD_CMD_WR_REG);

  // register-write filter under read protection
  wire in_flash = (waddr_q >= FLASH_LO) && (waddr_q <= FLASH_HI);
  wire wr_ok = !read_protect_i ||
               (in_flash && ((waddr_q != FLASH_CTRL) || (rx_byte_i == MASS_ERASE)));
  wire wdata_take = take && (state_q == DCD_ST_WDATA);

  // runtime counter restarts from zero as the program starts running
  wire run_start = cpu_running_i && !run_q;
  dcd_sat_counter #(
    .WIDTH(DCD_RT_WIDTH)
  ) u_runtime (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clr_i(run_start),
    .inc_i(cpu_running_i),
    .count_o(rt_count)
  );
  assign runtime_count_o = rt_count;

  // sequencing of commands, arguments and answers
  always_comb
  begin
    state_d = state_q;
    resp_d = resp_q;
    resp_cnt_d = resp_cnt_q;
    waddr_d = waddr_q;
    wcount_d = wcount_q;
    unique case (state_q)
      DCD_ST_IDLE:
      begin
        if (take && allowed)
        begin
          if (code == DCD_CMD_REV)
          begin
            resp_d = REV_WORD;
            resp_cnt_d = DCD_RESP_TWO;
            state_d = DCD_ST_RESP;
          end
          else if (code == DCD_CMD_STATUS)
          begin
            resp_d = {debug_status_byte_i, DCD_BYTE_ZERO};
            resp_cnt_d = DCD_RESP_ONE;
            state_d = DCD_ST_RESP;
          end
          else if (code == DCD_CMD_RUNTIME)
          begin
            resp_d = rt_count;
            resp_cnt_d = DCD_RESP_TWO;
            state_d = DCD_ST_RESP;
          end
          else if (code == DCD_CMD_WR_REG)
            state_d = DCD_ST_WADDR_HI;
          else
            state_d = DCD_ST_FWD;
        end
      end
      DCD_ST_RESP:
      begin
        if (sent)
        begin
          resp_d = {resp_q[7:0], DCD_BYTE_ZERO};
          resp_cnt_d = resp_cnt_q - DCD_RESP_ONE;
          if (resp_cnt_q == DCD_RESP_ONE)
            state_d = DCD_ST_IDLE;
        end
      end
      DCD_ST_WADDR_HI:
      begin
        if (take)
        begin
          waddr_d = {rx_byte_i[3:0], DCD_BYTE_ZERO};
          state_d = DCD_ST_WADDR_LO;
        end
      end
      DCD_ST_WADDR_LO:
      begin
        if (take)
        begin
          waddr_d = {waddr_q[11:8], rx_byte_i};
          state_d = DCD_ST_WCOUNT;
        end
      end
      DCD_ST_WCOUNT:
      begin
        if (take)
        begin
          wcount_d = rx_byte_i;
          state_d = (rx_byte_i == DCD_BYTE_ZERO) ? DCD_ST_IDLE : DCD_ST_WDATA;
        end
      end
      DCD_ST_WDATA:
      begin
        if (take)
        begin
          waddr_d = waddr_q + DCD_ADDR_ONE;
          wcount_d = wcount_q - DCD_COUNT_ONE;
          if (wcount_q == DCD_COUNT_ONE)
            state_d = DCD_ST_IDLE;
        end
      end
      DCD_ST_FWD:
      begin
        if (ce_i && cmd_done_i)
          state_d = DCD_ST_IDLE;
      end
      default:
        state_d = DCD_ST_IDLE;
    endcase
  end

  // state and answer registers
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= DCD_ST_IDLE;
      resp_q <= DCD_RT_ZERO;
      resp_cnt_q <= DCD_RESP_ONE;
      waddr_q <= {DCD_ADDR_HI_ZERO, DCD_BYTE_ZERO};
      wcount_q <= DCD_BYTE_ZERO;
      run_q <= 1'b0;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      resp_q <= resp_d;
      resp_cnt_q <= resp_cnt_d;
      waddr_q <= waddr_d;
      wcount_q <= wcount_d;
      run_q <= cpu_running_i;
    end
  end

  // one-cycle strobes towards the executor
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cmd_start_q <= 1'b0;
      cmd_code_q <= DCD_BYTE_ZERO;
      cmd_refused_q <= 1'b0;
      arg_valid_q <= 1'b0;
      arg_byte_q <= DCD_BYTE_ZERO;
      reg_wr_q <= 1'b0;
      reg_addr_q <= {DCD_ADDR_HI_ZERO, DCD_BYTE_ZERO};
      reg_data_q <= DCD_BYTE_ZERO;
    end
    else if (ce_i)
    begin
      cmd_start_q <= fwd_take;
      cmd_code_q <= idle_take ? code : cmd_code_q;
      cmd_refused_q <= idle_take && known && !allowed;
      arg_valid_q <= take && (state_q == DCD_ST_FWD);
      arg_byte_q <= take ? rx_byte_i : arg_byte_q;
      reg_wr_q <= wdata_take && wr_ok;
      reg_addr_q <= wdata_take ? waddr_q : reg_addr_q;
      reg_data_q <= wdata_take ? rx_byte_i : reg_data_q;
    end
  end

  assign cmd_start_o = cmd_start_q;
  assign cmd_code_o = cmd_code_q;
  assign cmd_refused_o = cmd_refused_q;
  assign arg_valid_o = arg_valid_q;
  assign arg_byte_o = arg_byte_q;
  assign reg_wr_o = reg_wr_q;
  assign reg_addr_o = reg_addr_q;
  assign reg_data_o = reg_data_q;

  // checks on the decoder behaviour
  a_wr_flash_only: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    reg_wr_o && $past(read_protect_i) |-> (reg_addr_o >= FLASH_LO) && (reg_addr_o <= FLASH_HI)
    && ((reg_addr_o != FLASH_CTRL) || (reg_data_o == MASS_ERASE)))
    else $error("protected write outside flash control");
  a_dbg_refuse: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    idle_take && need_dbg && !debug_mode_i |=> !cmd_start_o && cmd_refused_o
    && (state_q == DCD_ST_IDLE))
    else $error("debug-only command ran outside debug mode");
  a_prot_reject: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    idle_take && read_protect_i && prot_block |=> !cmd_start_o && (state_q == DCD_ST_IDLE))
    else $error("protected command not rejected");
  a_prot_allow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    idle_take && read_protect_i && debug_mode_i
    && ((code == DCD_CMD_RD_DMEM) || (code == DCD_CMD_RD_CRC))
    |=> cmd_start_o && (state_q == DCD_ST_FWD))
    else $error("data read or crc blocked by protection");
  a_no_rx_answer: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    tx_valid_o |-> !rx_ready_o)
    else $error("command bytes taken while answering");
  a_rev_order: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    tx_valid_o && (cmd_code_o == DCD_CMD_REV)
    |-> tx_byte_o == ((resp_cnt_q == DCD_RESP_TWO) ? REV_WORD[15:8] : REV_WORD[7:0]))
    else $error("revision bytes wrong or out of order");
  a_status_byte: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    idle_take && (code == DCD_CMD_STATUS)
    |=> tx_valid_o && (tx_byte_o == $past(debug_status_byte_i)) && (resp_cnt_q == DCD_RESP_ONE))
    else $error("status answer wrong");
  a_rt_count_up: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && cpu_running_i && run_q && (rt_count != DCD_RT_MAX)
    |=> rt_count == $past(rt_count) + DCD_RT_WIDTH'(1))
    else $error("runtime counter did not advance");
  a_rt_saturate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && run_q && (rt_count == DCD_RT_MAX) |=> rt_count == DCD_RT_MAX)
    else $error("runtime counter wrapped");
  a_rt_restart: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && run_start |=> rt_count == DCD_RT_ZERO)
    else $error("runtime counter not restarted from zero");
  a_reserved_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    idle_take && !known |=> (state_q == DCD_ST_IDLE) && !tx_valid_o && !cmd_start_o
    && !cmd_refused_o)
    else $error("reserved command had an effect");
  a_rt_high_first: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    idle_take && (code == DCD_CMD_RUNTIME) |=> tx_valid_o && (tx_byte_o == $past(rt_count[15:8])))
    else $error("runtime high byte not first");
endmodule
`default_nettype wire

/* testbench/dcd_host_model.sv */
// host side model: takes answer bytes with random stalls
`timescale 1ns/1ps
`default_nettype none
module dcd_host_model (
  input wire logic clock_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic stall_i,
  output logic tx_ready_o,
  output logic got_o,
  output logic [7:0] got_byte_o
);
  logic [3:0] pat_q;
  // known state at time zero
  initial
  begin
    pat_q = 4'h9;
    tx_ready_o = 1'b0;
    got_o = 1'b0;
    got_byte_o = 8'h00;
  end
  // ready pattern moves on the falling edge, away from sampling
  always @(negedge clock_i)
  begin
    pat_q <= {pat_q[2:0], pat_q[3] ^ pat_q[2]};
    tx_ready_o <= !(stall_i && pat_q[0]);
  end
  // latch each answer byte the host takes, with a one-cycle strobe
  always @(posedge clock_i)
  begin
    got_o <= tx_valid_i && tx_ready_o;
    if (tx_valid_i && tx_ready_o)
      got_byte_o <= tx_byte_i;
  end
endmodule
`default_nettype wire

/* testbench/dcd_decoder_bench.sv */
// self-checking bench for the debug command decoder
`timescale 1ns/1ps
`default_nettype none
module dcd_decoder_bench;
  import dcd_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic clock_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, rx_valid = 1'b0, rx_ready, tx_valid;
  logic [7:0] rx_byte = 8'h00, tx_byte, stat = 8'h00, code, argb, reg_data, gotb;
  logic tx_ready, dbg = 1'b0, prot = 1'b0, run = 1'b0, done = 1'b0, stall = 1'b1, got;
  logic start, refused, argv, reg_wr;
  logic [11:0] reg_addr;
  logic [15:0] rt;
  logic [31:0] lfsr_q = 32'h98C2;
  int mismatches = 0, n_checks = 0;
  // design and host model
  dcd_decoder i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_ready_o(rx_ready),
    .tx_valid_o(tx_valid), .tx_byte_o(tx_byte), .tx_ready_i(tx_ready),
    .debug_mode_i(dbg), .read_protect_i(prot), .cpu_running_i(run),
    .debug_status_byte_i(stat), .cmd_start_o(start), .cmd_code_o(code),
    .cmd_refused_o(refused), .arg_valid_o(argv), .arg_byte_o(argb), .cmd_done_i(done),
    .reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_data_o(reg_data), .runtime_count_o(rt));
  dcd_host_model i_host (.clock_i(clock_i), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte),
    .stall_i(stall), .tx_ready_o(tx_ready), .got_o(got), .got_byte_o(gotb));
  // 50 MHz clock
  always #10 clock_i = !clock_i;
  // expectations
  function automatic logic exp_known(input logic [7:0] c);
    return c >= DCD_CMD_WR_REG && c <= DCD_CMD_EXEC && c != DCD_CMD_RSVD_0F;
  endfunction
  function automatic logic exp_allow(input logic [7:0] c, input logic d, input logic p);
    return d && (!p || c == DCD_CMD_RD_DMEM || c == DCD_CMD_RD_CRC || c == DCD_CMD_WR_REG);
  endfunction
  function automatic logic exp_wr(input logic [11:0] a, input logic [7:0] d, input logic p);
    return !p || (a >= 12'hFF8 && (a != 12'hFF8 || d == 8'hA5));
  endfunction
  function automatic void rnd(output logic [7:0] v);
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    v = lfsr_q[7:0];
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout;
    mismatches++;
    finish_test();
  endtask
  // one host byte, held until taken; returns at the negedge after taking
  task automatic send(input logic [7:0] b);
    int i;
    @(negedge clock_i);
    rx_valid = 1'b1;
    rx_byte = b;
    for (i = 0; i < 60 && rx_ready !== 1'b1; i++)
      @(negedge clock_i);
    if (i == 60)
      timeout();
    @(negedge clock_i);
    rx_valid = 1'b0;
  endtask
  // one answer byte as seen by the host
  task automatic get(input logic [7:0] e);
    int i;
    @(negedge clock_i);
    for (i = 0; i < 60 && got !== 1'b1; i++)
      @(negedge clock_i);
    if (i == 60)
      timeout();
    `CHK(gotb, e)
  endtask
  // register write run with auto increment
  task automatic wr(input logic [11:0] a, input int n, input logic [7:0] d0);
    logic [7:0] d;
    send(DCD_CMD_WR_REG);
    send({4'h0, a[11:8]});
    send(a[7:0]);
    send(n[7:0]);
    for (int i = 0; i < n; i++)
    begin
      rnd(d);
      if (i == 0)
        d = d0;
      send(d);
      `CHK(reg_wr, exp_wr(a + i[11:0], d, prot))
      if (exp_wr(a + i[11:0], d, prot))
        `CHK({reg_addr, reg_data}, {a + i[11:0], d})
    end
  endtask
  // main sequence
  initial
  begin
    logic [7:0] b, c;
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    rst_n_i = 1'b1;
    `CHK({rx_ready, tx_valid, reg_wr, rt}, {3'b100, 16'h0000})
    send(DCD_CMD_REV);
    get(8'h01);
    get(8'h00);
    for (int j = 0; j < 4; j++)
    begin
      rnd(b);
      stat = b;
      send(DCD_CMD_STATUS);
      get(b);
      @(negedge clock_i);
      `CHK({tx_valid, rx_ready}, 2'b01)
    end
    for (int j = 0; j < 4; j++)
      for (c = DCD_CMD_WR_REG; c <= DCD_CMD_EXEC; c++)
      begin
        {dbg, prot} = j[1:0];
        send(c);
        `CHK(refused, exp_known(c) && !exp_allow(c, dbg, prot))
        `CHK(start, exp_known(c) && c != 8'h08 && exp_allow(c, dbg, prot))
        if (c == DCD_CMD_WR_REG && dbg)
          repeat (3) send(DCD_BYTE_ZERO);
        else if (start === 1'b1)
        begin
          rnd(b);
          send(b);
          `CHK({argv, argb}, {1'b1, b})
          done = 1'b1;
          @(negedge clock_i);
          done = 1'b0;
        end
      end
    dbg = 1'b1;
    prot = 1'b0;
    for (int j = 0; j < 12; j++)
    begin
      rnd(b);
      c = (j < 7) ? ((j < 1) ? 8'h01 : (j < 5) ? 8'h03 + j[7:0] : (j < 6) ? 8'h0F : 8'h13)
        : b | 8'h80;
      send(c);
      `CHK({tx_valid, start, refused, rx_ready, code}, {4'b0001, c})
    end
    wr(12'h123, 2, 8'h3C);
    prot = 1'b1;
    wr(12'hFF6, 4, 8'h11);
    wr(12'hFF8, 1, 8'hA5);
    wr(12'hFF8, 1, 8'h5A);
    wr(12'hFFF, 1, 8'h00);
    prot = 1'b0;
    run = 1'b1;
    repeat (100) @(negedge clock_i);
    run = 1'b0;
    repeat (5) @(negedge clock_i);
    `CHK(rt, 16'h0063)
    send(DCD_CMD_RUNTIME);
    get(8'h00);
    get(8'h63);
    run = 1'b1;
    repeat (65600) @(negedge clock_i);
    run = 1'b0;
    `CHK(rt, 16'hFFFF)
    send(DCD_CMD_RUNTIME);
    get(8'hFF);
    get(8'hFF);
    run = 1'b1;
    @(negedge clock_i);
    `CHK(rt, 16'h0000)
    // clock enable low freezes the running counter
    ce_i = 1'b0;
    repeat (5) @(negedge clock_i);
    `CHK(rt, 16'h0000)
    ce_i = 1'b1;
    @(negedge clock_i);
    `CHK(rt, 16'h0001)
    run = 1'b0;
    // reset in the middle of an answer
    send(DCD_CMD_REV);
    rst_n_i = 1'b0;
    @(negedge clock_i);
    rst_n_i = 1'b1;
    `CHK({rx_ready, tx_valid, rt}, {2'b10, 16'h0000})
    send(DCD_CMD_STATUS);
    get(stat);
    finish_test();
  end
endmodule
`default_nettype wire
